// [rtl/link_enhancement_control.sv]
// Purpose: Link enhancement set/clear register and async transmit threshold control
// Assumes: Link side consumes words with valid/ready; retries input is a level
// Notes: Config-space alias and EEPROM load share the same storage as the bus view
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module link_enhancement_control
  import link_enh_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cfg_wr_en,
  input wire logic [31:0] cfg_wr_data,
  output logic [31:0] cfg_rd_data,
  input wire logic eeprom_load,
  input wire logic [15:0] eeprom_data,
  input wire logic retries_zero,
  input wire logic [5:0] stream_format_code,
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  input wire tx_word_s tx_in,
  output logic tx_out_valid,
  input wire logic tx_out_ready,
  output tx_word_s tx_out,
  output logic tx_underrun,
  output logic async_tx_out_of_order_disable,
  output logic mpeg_timestamp_apply,
  output logic dv_cip_timestamp_apply,
  output logic priority_arb_enable,
  output logic accel_enable
);
  // ************************************************************
  // Declarations
  // ************************************************************
  localparam int CW = $clog2(FIFO_DEPTH) + 1;
  logic [15:0] link_q;
  logic [15:0] link_d;
  logic aw_hold_q;
  logic w_hold_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic [15:0] lane_mask;
  logic [31:0] read_val;
  logic read_hit;
  logic fallback_q;
  logic underrun_seen_q;
  tx_state_e state_q;
  logic [CW-1:0] eop_cnt_q;
  logic [CW-1:0] fifo_count;
  logic fifo_valid;
  tx_word_s fifo_data;
  logic pop;
  logic push_eop;
  logic pop_eop;
  logic underrun;
  logic force_sf;
  logic [15:0] thr_bytes;
  logic [15:0] fill_bytes;
  logic start;

  // ************************************************************
  // AXI4-Lite write path
  // ************************************************************
  assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign lane_mask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}} & WRITABLE_MASK;

  // Address and data taken in either order, response after both
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q[ADDR_W-1:2] == OFF_SET[11:2] ||
                        awaddr_q[ADDR_W-1:2] == OFF_CLEAR[11:2] ||
                        awaddr_q[ADDR_W-1:2] == OFF_STATUS[11:2]) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Shared register storage
  // ************************************************************
  // Later writers win: bus, then config alias, then EEPROM load
  always_comb begin
    link_d = link_q;
    if (do_write && awaddr_q[ADDR_W-1:2] == OFF_SET[11:2]) begin
      link_d = link_d | (wdata_q[15:0] & lane_mask);
    end
    if (do_write && awaddr_q[ADDR_W-1:2] == OFF_CLEAR[11:2]) begin
      link_d = link_d & ~(wdata_q[15:0] & lane_mask);
    end
    if (cfg_wr_en) begin
      link_d = cfg_wr_data[15:0] & WRITABLE_MASK;
    end
    if (eeprom_load) begin
      link_d = (link_d & ~EEPROM_MASK) | (eeprom_data & EEPROM_MASK);
    end
    link_d = link_d & WRITABLE_MASK;
  end

  // Bus view reads this copy; the config view keeps a mirror register loaded from the same link_d
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link_q <= LINK_RESET;
    end else if (ce) begin
      link_q <= link_d;
    end
  end

  // Config-space view of the same bits, upper half reserved
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_rd_data <= {16'h0000, LINK_RESET};
    end else if (ce) begin
      cfg_rd_data <= {16'h0000, link_d};
    end
  end

  // ************************************************************
  // AXI4-Lite read path
  // ************************************************************
  always_comb begin
    read_val = 32'h0000_0000;
    read_hit = 1'b1;
    if (s_axi_araddr[ADDR_W-1:2] == OFF_SET[11:2] ||
        s_axi_araddr[ADDR_W-1:2] == OFF_CLEAR[11:2]) begin
      read_val = {16'h0000, link_q};
    end else if (s_axi_araddr[ADDR_W-1:2] == OFF_STATUS[11:2]) begin
      read_val[ST_FALLBACK] = fallback_q;
      read_val[ST_UNDERRUN] = underrun_seen_q;
      read_val[ST_SENDING] = state_q == TX_SEND;
      read_val[ST_COUNT_LO +: CW] = fifo_count;
    end else begin
      read_hit = 1'b0;
    end
  end

  // Single-beat read answered one cycle after the address is taken
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_val;
        s_axi_rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Transmit FIFO and threshold control
  // ************************************************************
  link_enh_fifo #(.WIDTH($bits(tx_word_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .in_data(tx_in),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data),
    .count(fifo_count)
  );

  assign push_eop = tx_in_valid && tx_in_ready && tx_in.eop;
  assign pop = state_q == TX_SEND && fifo_valid && (!tx_out_valid || tx_out_ready);
  assign pop_eop = pop && fifo_data.eop;
  // Link wants a word and nothing is left mid-packet
  assign underrun = state_q == TX_SEND && !fifo_valid && (!tx_out_valid || tx_out_ready);
  assign force_sf = retries_zero || fallback_q;
  assign fill_bytes = 16'({fifo_count, 2'b00});

  // Threshold decode from the programmed field
  always_comb begin
    unique case (link_q[BIT_THR_LO +: 2])
      2'b00: thr_bytes = THR_2K;
      2'b01: thr_bytes = THR_1K7;
      2'b10: thr_bytes = THR_1K;
      2'b11: thr_bytes = THR_512;
    endcase
  end

  // Store-and-forward waits for a whole packet; code 00 is the 2K case
  assign start = eop_cnt_q != '0 ||
                 (!force_sf && link_q[BIT_THR_LO +: 2] != 2'b00 &&
                  fill_bytes >= thr_bytes);

  // Count of end-of-packet tokens sitting in the FIFO
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eop_cnt_q <= '0;
    end else if (ce) begin
      eop_cnt_q <= eop_cnt_q + CW'(push_eop) - CW'(pop_eop);
    end
  end

  // Transmit sequencer; an underrun drops back to waiting for the full packet
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= TX_IDLE;
    end else if (ce) begin
      unique case (state_q)
        TX_IDLE: if (start) state_q <= TX_SEND;
        TX_SEND: if (pop_eop || underrun) state_q <= TX_IDLE;
      endcase
    end
  end

  // Fallback holds until the retried packet has gone; set beats clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fallback_q <= 1'b0;
      underrun_seen_q <= 1'b0;
      tx_underrun <= 1'b0;
    end else if (ce) begin
      tx_underrun <= underrun;
      if (underrun) begin
        fallback_q <= 1'b1;
      end else if (pop_eop) begin
        fallback_q <= 1'b0;
      end
      if (underrun) begin
        underrun_seen_q <= 1'b1;
      end else if (do_write && awaddr_q[ADDR_W-1:2] == OFF_STATUS[11:2] &&
                   wstrb_q[0] && wdata_q[ST_UNDERRUN]) begin
        underrun_seen_q <= 1'b0;
      end
    end
  end

  // Output register toward the serial bus side
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_out_valid <= 1'b0;
      tx_out <= '0;
    end else if (ce) begin
      if (pop) begin
        tx_out_valid <= 1'b1;
        tx_out <= fifo_data;
      end else if (tx_out_ready) begin
        tx_out_valid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Enable outputs
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      async_tx_out_of_order_disable <= 1'b0;
      mpeg_timestamp_apply <= 1'b0;
      dv_cip_timestamp_apply <= 1'b0;
      priority_arb_enable <= 1'b0;
      accel_enable <= 1'b0;
    end else if (ce) begin
      async_tx_out_of_order_disable <= link_q[BIT_OOO_DIS];
      mpeg_timestamp_apply <= link_q[BIT_MPEG] && stream_format_code == FMT_MPEG;
      dv_cip_timestamp_apply <= link_q[BIT_DV] && stream_format_code == FMT_DV;
      priority_arb_enable <= link_q[BIT_PRIO];
      accel_enable <= link_q[BIT_ACCEL];
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  AST_ALIAS_READ: assert property (@(posedge clk) disable iff (!resetn)
    ce && s_axi_arvalid && s_axi_arready && s_axi_araddr[ADDR_W-1:2] == OFF_CLEAR[11:2]
    |=> s_axi_rdata == $past(cfg_rd_data))
    else $error("bus read differs from config view");
  AST_SET_WRITE: assert property (@(posedge clk) disable iff (!resetn)
    ce && do_write && !cfg_wr_en && !eeprom_load && wstrb_q == 4'hf &&
    awaddr_q[ADDR_W-1:2] == OFF_SET[11:2]
    |=> link_q == (($past(link_q) | $past(wdata_q[15:0])) & WRITABLE_MASK))
    else $error("set write wrong");
  AST_CLEAR_WRITE: assert property (@(posedge clk) disable iff (!resetn)
    ce && do_write && !cfg_wr_en && !eeprom_load && wstrb_q == 4'hf &&
    awaddr_q[ADDR_W-1:2] == OFF_CLEAR[11:2]
    |=> link_q == ($past(link_q) & ~$past(wdata_q[15:0])))
    else $error("clear write wrong");
  AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!resetn)
    (link_q & ~WRITABLE_MASK) == 16'h0000 && cfg_rd_data[31:16] == 16'h0000)
    else $error("reserved bit nonzero");
  AST_EEPROM_LOAD: assert property (@(posedge clk) disable iff (!resetn)
    ce && eeprom_load |=> (link_q & EEPROM_MASK) == ($past(eeprom_data) & EEPROM_MASK))
    else $error("eeprom load lost");
  AST_OOO_FOLLOWS: assert property (@(posedge clk) disable iff (!resetn)
    ce && cfg_wr_en && !eeprom_load && cfg_wr_data[BIT_OOO_DIS] ##1 ce
    |=> async_tx_out_of_order_disable)
    else $error("pipelining disable not applied");
  AST_SF_HOLDS: assert property (@(posedge clk) disable iff (!resetn)
    ce && state_q == TX_IDLE && eop_cnt_q == '0 && force_sf |=> state_q == TX_IDLE)
    else $error("store-and-forward violated");
  AST_THR_START: assert property (@(posedge clk) disable iff (!resetn)
    ce && state_q == TX_IDLE && !force_sf && link_q[BIT_THR_LO +: 2] != 2'b00 &&
    fill_bytes >= thr_bytes |=> state_q == TX_SEND)
    else $error("threshold start missed");
  AST_UNDERRUN_FALLBACK: assert property (@(posedge clk) disable iff (!resetn)
    ce && underrun |=> fallback_q && tx_underrun && state_q == TX_IDLE)
    else $error("underrun fallback missing");
  AST_MPEG_APPLY: assert property (@(posedge clk) disable iff (!resetn)
    ce && $past(ce) && mpeg_timestamp_apply |-> $past(stream_format_code) == FMT_MPEG)
    else $error("mpeg applied to wrong format");
  AST_DV_APPLY: assert property (@(posedge clk) disable iff (!resetn)
    ce && $past(ce) && dv_cip_timestamp_apply |-> $past(link_q[BIT_DV]))
    else $error("dv applied while disabled");
endmodule
`default_nettype wire

// [rtl/link_enh_pkg.sv]
// Purpose: Shared constants and types of the link enhancement control block
// Assumes: 32-bit AXI4-Lite register bus, 12-bit register address space
// Notes: Status register offset and serial-load mask are local choices
// Contract
// - The register is an alias of the configuration-space copy; both views share bits.
// - A present serial configuration memory may load some of the bits.
// - Bits 31-16, 14, 11, 9 and the other reserved bits read zero and ignore writes.
// - Bit 15 set stops out-of-order pipelining of async_transmit requests.
// - Threshold code 00 is 2K (store-and-forward), 01 1.7K, 10 1K, 11 512 bytes.
// - The programmed threshold holds until the first underrun; the retry uses 2K.
// - Below 2K, sending starts at the threshold fill or a whole packet, whichever first.
// - FIFO empty mid-packet is an underrun and forces store-and-forward for the retry.
// - With 2K selected, sending waits until the end-of-packet token is in the FIFO.
// - A cleared retries register forces store-and-forward whatever the threshold.
// - Bit 10 applies the MPEG timestamp enhancement to streams with format code 20h.
// - Bit 8 applies the DV CIP timestamp enhancement to streams with format code 00h.
// - Bit 7 lets the link answer requests with priority arbitration.
// - Bit 1 tells the physical layer the link supports acceleration enhancements.
package link_enh_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_SET = 12'h0a88;
  localparam logic [11:0] OFF_CLEAR = 12'h0a8c;
  localparam logic [11:0] OFF_STATUS = 12'h0b00;
  localparam logic [15:0] LINK_RESET = 16'h1000;
  localparam logic [15:0] WRITABLE_MASK = 16'hb582;
  localparam logic [15:0] EEPROM_MASK = 16'hb582;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int BIT_OOO_DIS = 15;
  localparam int BIT_THR_LO = 12;
  localparam int BIT_MPEG = 10;
  localparam int BIT_DV = 8;
  localparam int BIT_PRIO = 7;
  localparam int BIT_ACCEL = 1;
  localparam int ST_FALLBACK = 0;
  localparam int ST_UNDERRUN = 1;
  localparam int ST_SENDING = 2;
  localparam int ST_COUNT_LO = 4;

  // ************************************************************
  // Thresholds in bytes and stream format codes
  // ************************************************************
  localparam logic [15:0] THR_2K = 16'h0800;
  localparam logic [15:0] THR_1K7 = 16'h06cc;
  localparam logic [15:0] THR_1K = 16'h0400;
  localparam logic [15:0] THR_512 = 16'h0200;
  localparam logic [5:0] FMT_MPEG = 6'h20;
  localparam logic [5:0] FMT_DV = 6'h00;

  typedef struct packed {
    logic eop;
    logic [31:0] data;
  } tx_word_s;

  typedef enum logic [0:0] {TX_IDLE, TX_SEND} tx_state_e;
endpackage

// [rtl/link_enh_mem.sv]
// Purpose: Small storage array with registered read data
// Assumes: Write and read in the same clock; read address applied every cycle
// Notes: Same-address write bypasses into the read register
`timescale 1ns/1ps
`default_nettype none
module link_enh_mem #(
  parameter int W = 33,
  parameter int D = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [D];

  // Storage write
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read; bypass avoids stale data on write-then-read of one entry
  always_ff @(posedge clk) begin
    if (ce) begin
      rdata <= (we && waddr == raddr) ? wdata : mem[raddr];
    end
  end
endmodule
`default_nettype wire

// [rtl/link_enh_fifo.sv]
// Purpose: Transmit FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: Output data read ahead from the memory register
`timescale 1ns/1ps
`default_nettype none
module link_enh_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW-1:0] raddr;
  logic push;
  logic pop;
  logic [AW:0] count_d;

  // Handshakes and next fill level
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign raddr = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
  assign count_d = count + (AW+1)'(push) - (AW+1)'(pop);

  // Pointers, level and registered flags
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else if (ce) begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      count <= count_d;
      in_ready <= count_d != FULL;
      out_valid <= count_d != '0;
    end
  end

  link_enh_mem #(.W(WIDTH), .D(DEPTH), .AW(AW)) u_mem (
    .clk(clk),
    .ce(ce),
    .we(push),
    .waddr(wr_ptr_q),
    .wdata(in_data),
    .raddr(raddr),
    .rdata(out_data)
  );
endmodule
`default_nettype wire

// [testbench/link_sink.sv]
// Purpose: Serial-bus side model that takes async transmit words
// Assumes: A word moves at each edge with valid and ready high
// Notes: stall holds ready low to act as a slow link
`timescale 1ns/1ps
`default_nettype none
module link_sink
  import link_enh_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic stall,
  input wire logic tx_out_valid,
  input wire tx_word_s tx_out,
  output logic tx_out_ready,
  output var int words,
  output tx_word_s last
);
  // ********
  // Link side
  // ********
  // Plain level, so a slow link is one input away
  assign tx_out_ready = !stall;
  // Count words and keep the newest for the bench
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      words <= 0;
      last <= '0;
    end else if (tx_out_valid && tx_out_ready) begin
      words <= words + 1;
      last <= tx_out;
    end
  end
endmodule
`default_nettype wire

// [testbench/tb_link_enhancement_control.sv]
// Purpose: Self-checking bench for the link enhancement block
// Assumes: Deep FIFO so the 512-byte threshold can be reached
// Notes: Bus master keeps one read or write in flight
`timescale 1ns/1ps
`default_nettype none
module tb_link_enhancement_control
  import link_enh_pkg::*;
;
  // ********
  // Wiring
  // ********
  logic clk = 0;
  logic resetn = 0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, cfg_wr_data = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, cfg_wr_en = 0, eeprom_load = 0;
  logic retries_zero = 0, tx_in_valid = 0, stall = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [15:0] eeprom_data = '0;
  logic [5:0] stream_format_code = '0;
  tx_word_s tx_in = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic tx_in_ready, tx_out_valid, tx_out_ready, tx_underrun;
  logic async_tx_out_of_order_disable, mpeg_timestamp_apply, dv_cip_timestamp_apply;
  logic priority_arb_enable, accel_enable;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, cfg_rd_data, d;
  tx_word_s tx_out, last;
  int words, tk;
  int under_n = 0;
  int failures = 0;
  int checked = 0;

  link_enhancement_control #(.FIFO_DEPTH(256)) u_link_enhancement_control (
    .clk, .resetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg_wr_en,
    .cfg_wr_data, .cfg_rd_data, .eeprom_load, .eeprom_data, .retries_zero,
    .stream_format_code, .tx_in_valid, .tx_in_ready, .tx_in, .tx_out_valid,
    .tx_out_ready, .tx_out, .tx_underrun, .async_tx_out_of_order_disable,
    .mpeg_timestamp_apply, .dv_cip_timestamp_apply, .priority_arb_enable,
    .accel_enable);
  link_sink u_link_sink (.clk, .resetn, .stall, .tx_out_valid, .tx_out,
    .tx_out_ready, .words, .last);

  // 100 MHz clock
  always #5 clk = ~clk;
  // Underrun pulses last one cycle, so count them as they pass
  always @(posedge clk) if (tx_underrun === 1'b1) under_n <= under_n + 1;

  // ********
  // Helpers
  // ********
  task results;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task tmo;
    failures++;
    $display("wrong value wait expected done seen timeout");
    results();
  endtask
  // Wide enough for a whole transmit word or a data and response pair
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) tmo();
    rs = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) tmo();
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // Streams n words; ends early when the FIFO keeps refusing
  task automatic push(input int n, input logic eop, output int t);
    int c;
    t = 0;
    @(posedge clk);
    tx_in_valid <= 1;
    tx_in <= '{eop && n == 1, 32'ha500_0000};
    for (c = 0; c < n + 20 && t < n; c++) begin
      @(posedge clk);
      if (tx_in_ready) begin
        t++;
        tx_in <= '{eop && t == n - 1, 32'ha500_0000 + 32'(t)};
      end
    end
    tx_in_valid <= 0;
  endtask
  task automatic wait_words(input int n);
    int c;
    for (c = 0; c < 600 && words != n; c++) @(posedge clk);
    if (c == 600) tmo();
  endtask

  // ********
  // Scenarios
  // ********
  task t_reset;
    rd(OFF_SET, d, r);
    chk("reset value", {16'h0000, LINK_RESET}, d);
    chk("reset alias", {16'h0000, LINK_RESET}, cfg_rd_data);
  endtask
  task t_set_clear;
    wr(OFF_SET, 32'hffff_ffff, r);
    chk("set resp", RESP_OKAY, r);
    rd(OFF_CLEAR, d, r);
    chk("after set", {16'h0000, WRITABLE_MASK}, d);
    chk("ooo off", 1, async_tx_out_of_order_disable);
    chk("prio accel", 2'b11, {priority_arb_enable, accel_enable});
    wr(OFF_CLEAR, 32'h0000_8000, r);
    rd(OFF_SET, d, r);
    chk("after clear", {16'h0000, WRITABLE_MASK & 16'h7fff}, d);
    chk("ooo on", 0, async_tx_out_of_order_disable);
    // Low lane only: bits 7 and 1 clear, the upper lane is left alone
    s_axi_wstrb <= 4'h1;
    wr(OFF_CLEAR, 32'h0000_0182, r);
    s_axi_wstrb <= 4'hf;
    rd(OFF_SET, d, r);
    chk("lane strobe", 32'h0000_3500, d);
    chk("prio accel off", 0, {priority_arb_enable, accel_enable});
  endtask
  task automatic t_stamp;
    logic [5:0] code [3] = '{6'h05, 6'h20, 6'h00};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      stream_format_code <= code[i];
      cyc(3);
      chk("mpeg apply", code[i] == FMT_MPEG, mpeg_timestamp_apply);
      chk("dv apply", code[i] == FMT_DV, dv_cip_timestamp_apply);
    end
  endtask
  task t_alias;
    @(posedge clk);
    cfg_wr_en <= 1;
    cfg_wr_data <= 32'hffff_8400;
    @(posedge clk);
    cfg_wr_en <= 0;
    rd(OFF_SET, d, r);
    chk("alias write", 32'h0000_8400, d);
    chk("alias view", 32'h0000_8400, cfg_rd_data);
    chk("alias ooo", 1, async_tx_out_of_order_disable);
    eeprom_load <= 1;
    eeprom_data <= 16'hffff;
    @(posedge clk);
    eeprom_load <= 0;
    rd(OFF_CLEAR, d, r);
    chk("serial load", {16'h0000, EEPROM_MASK}, d);
    wr(12'h0a90, 32'hffff_ffff, r);
    chk("unmapped write", RESP_SLVERR, r);
    rd(12'h0a90, d, r);
    chk("unmapped read", {32'h0000_0000, RESP_SLVERR}, {d, r});
  endtask
  task t_store_fwd;
    wr(OFF_CLEAR, 32'h0000_3000, r);
    stall <= 1;
    push(2, 0, tk);
    cyc(8);
    chk("held for end token", 0, tx_out_valid);
    push(1, 1, tk);
    cyc(4);
    chk("slow link", {32'h0000_0000, 1'b1}, {words, tx_out_valid});
    stall <= 0;
    wait_words(3);
    chk("last word", {1'b1, 32'ha500_0000}, last);
  endtask
  task t_underrun;
    wr(OFF_SET, 32'h0000_3000, r);
    push(130, 0, tk);
    wait_words(133);
    cyc(3);
    chk("underrun pulses", 1, under_n);
    rd(OFF_STATUS, d, r);
    chk("status fallback", 32'h0000_0003, d);
    push(1, 0, tk);
    cyc(10);
    chk("no partial send", 133, words);
    push(1, 1, tk);
    wait_words(135);
    rd(OFF_STATUS, d, r);
    chk("status done", 32'h0000_0002, d);
  endtask
  task t_retries;
    @(posedge clk);
    retries_zero <= 1;
    push(260, 0, tk);
    chk("taken until full", 256, tk);
    chk("full refuses", 0, tx_in_ready);
    chk("nothing sent", 135, words);
  endtask

  // Reset, then every scenario in turn
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1;
    t_reset();
    t_set_clear();
    t_stamp();
    t_alias();
    t_store_fwd();
    t_underrun();
    t_retries();
    results();
  end
endmodule
`default_nettype wire
